// ### uac_pkg.sv
// uac_pkg: constants for the usb address, frame and endpoint control block
// assumes an 8-bit register port with one-cycle strobes
package uac_pkg;

    // ------------------------------------------------------------
    // register map (word index, plain port)
    // ------------------------------------------------------------
    localparam logic [3:0] UAC_OFS_ADDR     = 4'h0;
    localparam logic [3:0] UAC_OFS_FRM_LOW  = 4'h1;
    localparam logic [3:0] UAC_OFS_FRM_HIGH = 4'h2;
    localparam logic [3:0] UAC_OFS_EPC_BASE = 4'h8; // 0x8..0xe: ep 0..6

    localparam int         UAC_NUM_EP       = 7;

    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [6:0] UAC_ADDR_RST     = 7'h00;
    localparam logic [4:0] UAC_EPC_RST      = 5'h00;
    localparam logic [10:0] UAC_FRM_RST     = 11'h000;
    localparam int         UAC_EPC_CDIS     = 4;
    localparam int         UAC_EPC_RXEN     = 3;
    localparam int         UAC_EPC_TXEN     = 2;
    localparam int         UAC_EPC_HALT     = 1;
    localparam int         UAC_EPC_HSHK     = 0;

    // ------------------------------------------------------------
    // token pids and handshake answers
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        UAC_TOK_OUT   = 2'b00,
        UAC_TOK_IN    = 2'b01,
        UAC_TOK_SOF   = 2'b10,
        UAC_TOK_SETUP = 2'b11
    } uac_tok_t;

    typedef enum logic [1:0]
    {
        UAC_HS_NONE  = 2'b00,
        UAC_HS_ACK   = 2'b01,
        UAC_HS_NAK   = 2'b10,
        UAC_HS_STALL = 2'b11
    } uac_hs_t;

endpackage

// ### uac_ep_decode.sv
// uac_ep_decode: combinational verdict for one token against one endpoint
// assumes the endpoint control bits of the selected endpoint at its input
`timescale 1ns/10ps
module uac_ep_decode
(
    input  wire logic [4:0]        epc,       // endpoint control bits
    input  wire uac_pkg::uac_tok_t tok,       // token kind
    input  wire logic              ready,     // buffer ready to move data
    output logic                   accept,    // endpoint takes the token
    output uac_pkg::uac_hs_t       hs         // handshake to send
);
    import uac_pkg::*;

    logic rxen;
    logic txen;
    logic enabled;

    assign rxen    = epc[UAC_EPC_RXEN];
    assign txen    = epc[UAC_EPC_TXEN];
    assign enabled = rxen | txen;

    // direction and halt decode
    always_comb
    begin
        accept = 1'b0;
        hs     = UAC_HS_NONE;
        if (enabled)
        begin
            case (tok)
                UAC_TOK_IN:    accept = txen;
                UAC_TOK_OUT:   accept = rxen;
                UAC_TOK_SETUP: accept = rxen & txen &
                                        ~epc[UAC_EPC_CDIS];
                default:       accept = 1'b0;
            endcase
            if (epc[UAC_EPC_HALT])
            begin
                accept = 1'b1;
                hs     = UAC_HS_STALL;
            end
            else if (accept && epc[UAC_EPC_HSHK])
                hs = ready ? UAC_HS_ACK : UAC_HS_NAK;
        end
    end

endmodule

// ### uac_frame_reg.sv
// uac_frame_reg: frame number capture from start-of-frame tokens
// assumes sof_valid is a one-cycle pulse with the frame number beside it
`timescale 1ns/10ps
module uac_frame_reg
(
    input  wire logic        clk_sys,   // system clock
    input  wire logic        rst_b,     // synchronous reset, low
    input  wire logic        sof_valid, // sof token seen
    input  wire logic [10:0] sof_frame, // frame number of the token
    output logic      [10:0] frame_q    // captured frame number
);
    import uac_pkg::*;

    typedef struct packed
    {
        logic [10:0] frame;
    } uac_frm_st_t;

    uac_frm_st_t s_q;
    uac_frm_st_t s_d;

    // load on each sof
    always_comb
    begin
        s_d = s_q;
        if (sof_valid)
            s_d.frame = sof_frame;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            s_q <= '{frame: UAC_FRM_RST};
        else
            s_q <= s_d;
    end

    assign frame_q = s_q.frame;

endmodule

// ### uac_ctrl.sv
// uac_ctrl: usb device address, frame number and endpoint control
// Operation
// - a 7-bit bus address is held and only tokens to it are answered.
// - the address clears to zero on system reset and on usb bus reset.
// - frame bits 7..0 read in bits 7..0 of the low frame register.
// - frame bits 10..8 read in bits 2..0 of the high frame register.
// - the frame registers load the frame number on every sof token.
// - endpoints 0 to 6 each own a control register with enable bits.
// - a halted endpoint with rx or tx enabled answers every access with a stall handshake.
// - halt overrides all other bits but only with rx or tx enabled.
// - a halted endpoint stays halted until software clears the bit.
// - ack and nak handshakes are sent only while the handshake bit is one; stall is sent with it zero too.
// - an endpoint with both enables clear is disabled.
// - tx enable alone accepts in transfers only.
// - rx enable alone accepts out transfers only.
// - both enables with control disable zero also accept setup.
// assumes a token decoder upstream giving one-cycle token pulses
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
module uac_ctrl
#(
    parameter int NUM_EP = 7                // endpoints in use
)
(
    input  wire logic              clk_sys,   // system clock 25 mhz
    input  wire logic              rst_b,     // synchronous reset, low
    input  wire logic              bus_reset, // usb bus reset decoded
    input  wire logic [3:0]        reg_addr,  // register index
    input  wire logic [7:0]        reg_wdata, // write data
    input  wire logic              reg_wr,    // write strobe
    input  wire logic              reg_rd,    // read strobe
    output logic      [7:0]        reg_rdata, // read data, next cycle
    input  wire logic              tok_valid, // token received pulse
    input  wire uac_pkg::uac_tok_t tok_kind,  // token kind
    input  wire logic [6:0]        tok_addr,  // token address field
    input  wire logic [3:0]        tok_ep,    // token endpoint field
    input  wire logic [10:0]       tok_frame, // sof frame number
    input  wire logic              ep_ready,  // buffer ready for data
    output logic                   tok_take,  // token accepted pulse
    output logic                   tok_dir_in,// accepted token is in
    output logic      [3:0]        tok_ep_q,  // accepted endpoint
    output logic                   hs_valid,  // handshake request pulse
    output uac_pkg::uac_hs_t       hs_kind    // handshake kind
);
    import uac_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [6:0]            addr;
        logic [NUM_EP-1:0][4:0] epc;
        logic [7:0]            rdata;
        logic                  take;
        logic                  dir_in;
        logic [3:0]            ep;
        logic                  hs_v;
        uac_hs_t               hs;
    } uac_st_t;

    uac_st_t s_q;
    uac_st_t s_d;

    logic [10:0] frame_q;
    logic        sof_valid;
    logic [4:0]  sel_epc;
    logic        dec_accept;
    uac_hs_t     dec_hs;
    logic        ep_ok;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // endpoint index for a register index, NUM_EP when not an endpoint
    function automatic logic [3:0] ep_of_reg(input logic [3:0] a);
        logic [3:0] d;
        d = a - UAC_OFS_EPC_BASE;
        if (a >= UAC_OFS_EPC_BASE && d < 4'(NUM_EP))
            return d;
        return 4'(NUM_EP);
    endfunction

    // ------------------------------------------------------------
    // frame number capture
    // ------------------------------------------------------------
    assign sof_valid = tok_valid && tok_kind == UAC_TOK_SOF;

    uac_frame_reg u_frame
    (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .sof_valid (sof_valid),
        .sof_frame (tok_frame),
        .frame_q   (frame_q)
    );

    // ------------------------------------------------------------
    // endpoint verdict
    // ------------------------------------------------------------
    assign ep_ok   = tok_ep < 4'(NUM_EP);
    assign sel_epc = ep_ok ? s_q.epc[tok_ep[2:0]] : 5'h00;

    uac_ep_decode u_dec
    (
        .epc    (sel_epc),
        .tok    (tok_kind),
        .ready  (ep_ready),
        .accept (dec_accept),
        .hs     (dec_hs)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [3:0] wi;
        logic [3:0] ri;
        wi       = ep_of_reg(reg_addr);
        ri       = ep_of_reg(reg_addr);
        s_d      = s_q;
        s_d.take = 1'b0;
        s_d.hs_v = 1'b0;
        s_d.rdata = 8'h00;

        // register writes
        if (reg_wr)
        begin
            if (reg_addr == UAC_OFS_ADDR)
                s_d.addr = reg_wdata[6:0];
            else if (wi < 4'(NUM_EP))
                s_d.epc[wi[2:0]] = reg_wdata[4:0];
        end

        // register reads, data in the next cycle only
        if (reg_rd)
        begin
            case (reg_addr)
                UAC_OFS_ADDR:     s_d.rdata = {1'b0, s_q.addr};
                UAC_OFS_FRM_LOW:  s_d.rdata = frame_q[7:0];
                UAC_OFS_FRM_HIGH: s_d.rdata = {5'h00,
                                               frame_q[10:8]};
                default:
                begin
                    if (ri < 4'(NUM_EP))
                        s_d.rdata = {3'h0, s_q.epc[ri[2:0]]};
                    else
                        s_d.rdata = 8'h00;
                end
            endcase
        end

        // token handling: address match and endpoint enabled
        if (tok_valid && tok_kind != UAC_TOK_SOF &&
            tok_addr == s_q.addr && ep_ok && dec_accept)
        begin
            s_d.take   = 1'b1;
            s_d.dir_in = tok_kind == UAC_TOK_IN;
            s_d.ep     = tok_ep;
            s_d.hs_v   = dec_hs != UAC_HS_NONE;
            s_d.hs     = dec_hs;
        end

        // bus reset returns to the default address
        if (bus_reset)
        begin
            s_d.addr = UAC_ADDR_RST;
            s_d.take = 1'b0;
            s_d.hs_v = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            s_q.addr   <= UAC_ADDR_RST;
            s_q.epc    <= '0;
            s_q.rdata  <= 8'h00;
            s_q.take   <= 1'b0;
            s_q.dir_in <= 1'b0;
            s_q.ep     <= 4'h0;
            s_q.hs_v   <= 1'b0;
            s_q.hs     <= UAC_HS_NONE;
        end
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata  = s_q.rdata;
    assign tok_take   = s_q.take;
    assign tok_dir_in = s_q.dir_in;
    assign tok_ep_q   = s_q.ep;
    assign hs_valid   = s_q.hs_v;
    assign hs_kind    = s_q.hs;

endmodule

// ### uac_ctrl_monitor.sv
// uac_ctrl_monitor: port checks for uac_ctrl
// assumes one clock, bound into every uac_ctrl
`timescale 1ns/10ps
module uac_ctrl_monitor
#(
    parameter int NUM_EP = 7               // endpoints in use
)
(
    input wire logic              clk_sys,   // clock
    input wire logic              rst_b,     // reset, low
    input wire logic              bus_reset, // usb bus reset
    input wire logic [3:0]        reg_addr,  // register index
    input wire logic [7:0]        reg_wdata, // write data
    input wire logic              reg_wr,    // write strobe
    input wire logic              reg_rd,    // read strobe
    input wire logic [7:0]        reg_rdata, // read data
    input wire logic              tok_valid, // token pulse
    input wire uac_pkg::uac_tok_t tok_kind,  // token kind
    input wire logic [6:0]        tok_addr,  // token address
    input wire logic [3:0]        tok_ep,    // token endpoint
    input wire logic              ep_ready,  // buffer ready
    input wire logic              tok_take,  // token taken
    input wire logic              tok_dir_in,// taken token is in
    input wire logic [3:0]        tok_ep_q,  // taken endpoint
    input wire logic              hs_valid,  // handshake pulse
    input wire uac_pkg::uac_hs_t  hs_kind    // handshake kind
);
    import uac_pkg::*;
    logic [6:0] adr_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // shadow of the bus address
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || bus_reset)
            adr_q <= 7'h00;
        else if (reg_wr && reg_addr == UAC_OFS_ADDR)
            adr_q <= reg_wdata[6:0];
    end

    a_addr_match: assert property (tok_take |-> $past(tok_addr) == $past(adr_q))
        else $error("token taken for another address");
    a_addr_read: assert property (reg_rd && reg_addr == UAC_OFS_ADDR
        |=> reg_rdata == {1'b0, $past(adr_q)}) else $error("address reads wrong");
    a_bus_reset_quiet: assert property (bus_reset |=> !tok_take && !hs_valid)
        else $error("answer during bus reset");
    a_frame_high: assert property (reg_rd && reg_addr == UAC_OFS_FRM_HIGH
        |=> reg_rdata[7:3] == 5'h00) else $error("frame high bits set");
    a_sof_no_take: assert property (tok_valid && tok_kind == UAC_TOK_SOF
        |=> !tok_take) else $error("sof taken as transfer");
    a_ep_range: assert property (tok_take |-> tok_ep_q == $past(tok_ep)
        && tok_ep_q < NUM_EP) else $error("bad taken endpoint");
    a_dir_in: assert property (tok_take
        |-> tok_dir_in == ($past(tok_kind) == UAC_TOK_IN)) else $error("bad dir");
    a_ack_ready: assert property (hs_valid && hs_kind == UAC_HS_ACK
        |-> $past(ep_ready) && $past(tok_valid)) else $error("ack not ready");
    cover property (hs_valid && hs_kind == UAC_HS_STALL);
    cover property (tok_take && !hs_valid);
    cover property (bus_reset);
endmodule

bind uac_ctrl uac_ctrl_monitor #(.NUM_EP(NUM_EP)) u_mon (
    .clk_sys(clk_sys), .rst_b(rst_b), .bus_reset(bus_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tok_valid(tok_valid),
    .tok_kind(tok_kind), .tok_addr(tok_addr), .tok_ep(tok_ep),
    .ep_ready(ep_ready), .tok_take(tok_take), .tok_dir_in(tok_dir_in),
    .tok_ep_q(tok_ep_q), .hs_valid(hs_valid), .hs_kind(hs_kind));

// ### uac_host_model.sv
// uac_host_model: usb host issuing one token per send call
// assumes send is entered just after a rising clock edge
`timescale 1ns/10ps
module uac_host_model
(
    input  wire logic         clk_sys,   // system clock
    output logic              tok_valid, // token pulse
    output uac_pkg::uac_tok_t tok_kind,  // token kind
    output logic [6:0]        tok_addr,  // address field
    output logic [3:0]        tok_ep,    // endpoint field
    output logic [10:0]       tok_frame  // sof frame number
);
    import uac_pkg::*;

    // bus idle at start
    initial
    begin
        tok_valid = 1'b0;
        tok_kind = UAC_TOK_OUT;
        tok_addr = 7'h00;
        tok_ep = 4'h0;
        tok_frame = 11'h000;
    end

    // one token cycle, then the address, endpoint and frame fields no longer hold their value
    task automatic send(input uac_tok_t k, input logic [6:0] a,
                        input logic [3:0] e, input logic [10:0] f);
        tok_valid <= 1'b1;
        tok_kind <= k;
        tok_addr <= a;
        tok_ep <= e;
        tok_frame <= f;
        @(posedge clk_sys);
        tok_valid <= 1'b0;
        tok_addr <= ~a;
        tok_ep <= ~e;
        tok_frame <= ~f;
    endtask
endmodule

// ### tb_top.sv
// tb_top: self-checking bench for uac_ctrl
// assumes uac_host_model on the token side
`timescale 1ns/10ps
module tb_top;
    import uac_pkg::*;
    logic clk_sys, rst_b, bus_reset, reg_wr, reg_rd, ep_ready;
    logic [3:0] reg_addr, tok_ep, tok_ep_q;
    logic [7:0] reg_wdata, reg_rdata;
    logic [6:0] tok_addr;
    logic [10:0] tok_frame;
    logic tok_valid, tok_take, tok_dir_in, hs_valid;
    uac_tok_t tok_kind;
    uac_hs_t hs_kind;
    int mismatches = 0;
    int n_checks = 0;

    uac_ctrl DUT (.clk_sys(clk_sys), .rst_b(rst_b), .bus_reset(bus_reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tok_valid(tok_valid),
        .tok_kind(tok_kind), .tok_addr(tok_addr), .tok_ep(tok_ep),
        .tok_frame(tok_frame), .ep_ready(ep_ready), .tok_take(tok_take),
        .tok_dir_in(tok_dir_in), .tok_ep_q(tok_ep_q),
        .hs_valid(hs_valid), .hs_kind(hs_kind));
    uac_host_model u_host (.clk_sys(clk_sys), .tok_valid(tok_valid),
        .tok_kind(tok_kind), .tok_addr(tok_addr), .tok_ep(tok_ep),
        .tok_frame(tok_frame));

    // 25 mhz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic chk(input string nm, input logic [7:0] exp, got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one register cycle, w picks write or read
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e, string nm);
        bus(1'b0, a, 8'h00);
        chk(nm, e, reg_rdata);
    endtask

    // token, then judge the answer cycle
    task automatic tk(input uac_tok_t k, input logic [6:0] a,
                      input logic [3:0] e, input logic t, input uac_hs_t h);
        u_host.send(k, a, e, 11'h000);
        #1;
        chk("tok_take", {7'h00, t}, {7'h00, tok_take});
        chk("hs", {6'h00, h}, hs_valid ? {6'h00, hs_kind} : 8'h00);
        // direction and endpoint of a taken token
        if (t)
        begin
            chk("dir_in", {7'h00, k == UAC_TOK_IN}, {7'h00, tok_dir_in});
            chk("ep_q", {4'h0, e}, {4'h0, tok_ep_q});
        end
    endtask

    task automatic t_reset();
        rd(UAC_OFS_ADDR, 8'h00, "addr");
        for (int i = 0; i < 7; i++)
            rd(UAC_OFS_EPC_BASE + 4'(i), 8'h00, "epc");
        bus(1'b1, UAC_OFS_EPC_BASE + 4'h6, 8'hff);
        rd(UAC_OFS_EPC_BASE + 4'h6, 8'h1f, "epc6");
        rd(4'h3, 8'h00, "unmapped");
        $display("t_reset done");
    endtask

    task automatic t_addr();
        bus(1'b1, UAC_OFS_EPC_BASE, 8'h0d);
        tk(UAC_TOK_SETUP, 7'h00, 4'h0, 1'b1, UAC_HS_ACK);
        bus(1'b1, UAC_OFS_ADDR, 8'h2a);
        rd(UAC_OFS_ADDR, 8'h2a, "addr");
        tk(UAC_TOK_IN, 7'h00, 4'h0, 1'b0, UAC_HS_NONE);
        tk(UAC_TOK_IN, 7'h2a, 4'h0, 1'b1, UAC_HS_ACK);
        tk(UAC_TOK_IN, 7'h2a, 4'h7, 1'b0, UAC_HS_NONE);
        bus_reset <= 1'b1;
        @(posedge clk_sys);
        bus_reset <= 1'b0;
        #1;
        rd(UAC_OFS_ADDR, 8'h00, "addr");
        rd(UAC_OFS_EPC_BASE, 8'h0d, "epc0");
        $display("t_addr done");
    endtask

    task automatic t_dir();
        logic [4:0] c [5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h1c};
        uac_tok_t ks [3] = '{UAC_TOK_OUT, UAC_TOK_IN, UAC_TOK_SETUP};
        logic acc;
        foreach (c[i])
        begin
            bus(1'b1, UAC_OFS_EPC_BASE + 4'h1, {3'h0, c[i] | 5'h01});
            foreach (ks[j])
            begin
                acc = (j == 0) ? c[i][3] : (j == 1) ? c[i][2]
                    : c[i][3] & c[i][2] & !c[i][4];
                tk(ks[j], 7'h00, 4'h1, acc, acc ? UAC_HS_ACK : UAC_HS_NONE);
            end
        end
        $display("t_dir done");
    endtask

    task automatic t_halt();
        bus(1'b1, UAC_OFS_EPC_BASE + 4'h2, 8'h06);
        tk(UAC_TOK_IN, 7'h00, 4'h2, 1'b1, UAC_HS_STALL);
        tk(UAC_TOK_OUT, 7'h00, 4'h2, 1'b1, UAC_HS_STALL);
        bus(1'b1, UAC_OFS_EPC_BASE + 4'h2, 8'h03);
        tk(UAC_TOK_IN, 7'h00, 4'h2, 1'b0, UAC_HS_NONE);
        bus(1'b1, UAC_OFS_EPC_BASE + 4'h2, 8'h05);
        tk(UAC_TOK_IN, 7'h00, 4'h2, 1'b1, UAC_HS_ACK);
        ep_ready <= 1'b0;
        tk(UAC_TOK_IN, 7'h00, 4'h2, 1'b1, UAC_HS_NAK);
        bus(1'b1, UAC_OFS_EPC_BASE + 4'h2, 8'h04);
        tk(UAC_TOK_IN, 7'h00, 4'h2, 1'b1, UAC_HS_NONE);
        ep_ready <= 1'b1;
        $display("t_halt done");
    endtask

    task automatic t_frame();
        u_host.send(UAC_TOK_SOF, 7'h00, 4'h0, 11'h5a3);
        #1;
        chk("sof take", 8'h00, {7'h00, tok_take});
        rd(UAC_OFS_FRM_LOW, 8'ha3, "frm_lo");
        rd(UAC_OFS_FRM_HIGH, 8'h05, "frm_hi");
        u_host.send(UAC_TOK_SOF, 7'h33, 4'h0, 11'h2ff);
        rd(UAC_OFS_FRM_HIGH, 8'h02, "frm_hi");
        $display("t_frame done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // watchdog against a hung run
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        wrap_up();
    end

    // reset, then the scenarios
    initial
    begin
        rst_b = 1'b0;
        bus_reset = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        ep_ready = 1'b1;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        #1;
        t_reset();
        t_addr();
        t_dir();
        t_halt();
        t_frame();
        wrap_up();
    end
endmodule
